// File: core/epc_cell_array.sv
`timescale 1ns/1ps
`default_nettype none
module epc_cell_array #(
  parameter int ADDR_W = 11,
  parameter int DEPTH = 2048,
  parameter int DATA_W = 8
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [ADDR_W-1:0] wrAddr,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [ADDR_W-1:0] rdAddr,
  output logic [DATA_W-1:0] rdData
);
  // ----------------------------------------------------------------
  // cell storage
  // ----------------------------------------------------------------
  // no reset: a nonvolatile array keeps its contents through reset
  logic [DATA_W-1:0] cellMem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      cellMem[wrAddr] <= wrData;
    end
  end

  // combinational read keeps the bus wait state down to one cycle
  assign rdData = cellMem[rdAddr];
endmodule
`default_nettype wire

// File: core/epc_top.sv
`timescale 1ns/1ps
`default_nettype none
module epc_top #(
  parameter int PROG_CYCLES = epc_pkg::PROG_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq
);
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam int AW = epc_pkg::EE_ADDR_W;
  localparam int BW = epc_pkg::BYTE_SEL_W;
  localparam int PW = epc_pkg::PAGE_SEL_W;
  localparam int IW = epc_pkg::IRQ_W;

  // ----------------------------------------------------------------
  // ahb-lite slave front end
  // ----------------------------------------------------------------
  logic addrTake;
  logic [7:0] addrQ;
  logic wrPendQ;
  logic rdPendQ;
  logic hreadyoutQ;
  logic [31:0] hrdataQ;
  logic hrespQ;
  logic irqQ;

  // only whole-word transfers are expected, so hsize is not decoded
  assign addrTake = hsel && htrans[1] && hready;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      addrQ <= 8'h00;
      wrPendQ <= 1'b0;
      rdPendQ <= 1'b0;
    end else begin
      wrPendQ <= addrTake && hwrite;
      rdPendQ <= addrTake && !hwrite;
      if (addrTake) begin
        addrQ <= haddr[7:0];
      end
    end
  end

  // reads take one wait state so read data comes from a flop
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hreadyoutQ <= 1'b1;
    end else if (addrTake && !hwrite) begin
      hreadyoutQ <= 1'b0;
    end else if (rdPendQ) begin
      hreadyoutQ <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrespQ <= 1'b0;
    end else begin
      hrespQ <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // decoded strobes
  // ----------------------------------------------------------------
  logic ctrlWr;
  logic dataWr;
  logic [3:0] launchNib;
  logic mapQ;
  logic busyQ;
  logic pendQ;
  logic launch;
  logic abortEv;
  logic doneEv;
  logic eeLoad;
  logic xramWr;
  logic newPage;
  logic [AW-1:0] dptrQ;
  logic [PW-1:0] pageQ;

  assign ctrlWr = wrPendQ && (addrQ == epc_pkg::OFS_CTRL);
  assign dataWr = wrPendQ && (addrQ == epc_pkg::OFS_DATA);
  assign launchNib =
    hwdata[epc_pkg::CTRL_LAUNCH_MSB:epc_pkg::CTRL_LAUNCH_LSB];
  // latch loads are dropped while a page is being written
  assign eeLoad = dataWr && mapQ && !busyQ;
  assign xramWr = dataWr && !mapQ;
  assign newPage = dptrQ[AW-1:BW] != pageQ;

  // ----------------------------------------------------------------
  // control register and launch sequence
  // ----------------------------------------------------------------
  // second code is refused while busy, which counts as an abort
  assign launch = ctrlWr && (launchNib == epc_pkg::LAUNCH_SECOND) &&
                  pendQ && !busyQ;
  // any transfer at all between the two codes breaks the sequence
  assign abortEv = pendQ && (rdPendQ || wrPendQ) && !launch;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mapQ <= epc_pkg::RST_MAP;
    end else if (ctrlWr) begin
      mapQ <= hwdata[epc_pkg::CTRL_MAP_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pendQ <= 1'b0;
    end else if (wrPendQ || rdPendQ) begin
      pendQ <= ctrlWr && (launchNib == epc_pkg::LAUNCH_FIRST);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      dptrQ <= '0;
    end else if (wrPendQ && (addrQ == epc_pkg::OFS_DATA_POINTER)) begin
      dptrQ <= hwdata[AW-1:0];
    end
  end

  // ----------------------------------------------------------------
  // column latches with per-byte markers
  // ----------------------------------------------------------------
  logic [7:0] latchMem [epc_pkg::PAGE_BYTES];
  logic [epc_pkg::PAGE_BYTES-1:0] markQ;

  always_ff @(posedge sys_clk) begin
    if (eeLoad) begin
      latchMem[dptrQ[BW-1:0]] <= hwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pageQ <= '0;
    end else if (eeLoad) begin
      pageQ <= dptrQ[AW-1:BW];
    end
  end

  for (genvar i = 0; i < epc_pkg::PAGE_BYTES; i++) begin : g_mark
    localparam logic [BW-1:0] IDX = BW'(i);
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        markQ[i] <= 1'b0;
      end else if (doneEv) begin
        markQ[i] <= 1'b0;
      end else if (eeLoad) begin
        if (dptrQ[BW-1:0] == IDX) begin
          markQ[i] <= 1'b1;
        end else if (newPage) begin
          markQ[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // page programming sequencer
  // ----------------------------------------------------------------
  epc_pkg::epc_state_t stateQ;
  logic [BW-1:0] idxQ;
  logic [CNT_W-1:0] cntQ;
  logic cellWe;
  logic [7:0] cellRd;

  assign doneEv = (stateQ == epc_pkg::ST_WAIT) &&
                  (cntQ == CNT_W'(PROG_CYCLES - 1));
  // unmarked bytes are skipped so the old cell contents survive
  assign cellWe = (stateQ == epc_pkg::ST_COPY) && markQ[idxQ];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stateQ <= epc_pkg::ST_IDLE;
      idxQ <= '0;
      cntQ <= '0;
      busyQ <= epc_pkg::RST_BUSY;
    end else begin
      case (stateQ)
        epc_pkg::ST_IDLE: begin
          if (launch) begin
            stateQ <= epc_pkg::ST_COPY;
            idxQ <= '0;
            busyQ <= 1'b1;
          end
        end
        epc_pkg::ST_COPY: begin
          idxQ <= idxQ + 1'b1;
          if (idxQ == BW'(epc_pkg::PAGE_BYTES - 1)) begin
            stateQ <= epc_pkg::ST_WAIT;
            cntQ <= '0;
          end
        end
        epc_pkg::ST_WAIT: begin
          cntQ <= cntQ + 1'b1;
          if (doneEv) begin
            stateQ <= epc_pkg::ST_IDLE;
            busyQ <= 1'b0;
          end
        end
        default: begin
          stateQ <= epc_pkg::ST_IDLE;
          busyQ <= 1'b0;
        end
      endcase
    end
  end

  epc_cell_array #(
    .ADDR_W(AW),
    .DEPTH(epc_pkg::EE_BYTES),
    .DATA_W(8)
  ) u_cells (
    .clk(sys_clk),
    .wrEn(cellWe),
    .wrAddr({pageQ, idxQ}),
    .wrData(latchMem[idxQ]),
    .rdAddr(dptrQ),
    .rdData(cellRd)
  );

  // ----------------------------------------------------------------
  // xram behind the same data window
  // ----------------------------------------------------------------
  logic [7:0] xramMem [epc_pkg::XRAM_BYTES];
  logic [7:0] xramRd;

  always_ff @(posedge sys_clk) begin
    if (xramWr) begin
      xramMem[dptrQ[epc_pkg::XRAM_ADDR_W-1:0]] <= hwdata[7:0];
    end
  end
  assign xramRd = xramMem[dptrQ[epc_pkg::XRAM_ADDR_W-1:0]];

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [IW-1:0] statQ;
  logic [IW-1:0] maskQ;
  logic [IW-1:0] evVec;

  assign evVec = {abortEv, doneEv};

  // an event in the clearing read's cycle stays set
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      statQ <= '0;
    end else if (rdPendQ && (addrQ == epc_pkg::OFS_ISTAT)) begin
      statQ <= evVec;
    end else begin
      statQ <= statQ | evVec;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      maskQ <= '0;
    end else if (wrPendQ && (addrQ == epc_pkg::OFS_IMASK)) begin
      maskQ <= hwdata[IW-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irqQ <= 1'b0;
    end else begin
      irqQ <= |(statQ & maskQ);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [7:0] rdMux;

  always_comb begin
    rdMux = 8'h00;
    case (addrQ)
      epc_pkg::OFS_CTRL: begin
        rdMux = {6'h00, mapQ, busyQ};
      end
      epc_pkg::OFS_DATA_POINTER: begin
        rdMux = dptrQ[7:0];
      end
      epc_pkg::OFS_DATA: begin
        if (!mapQ) begin
          rdMux = xramRd;
        end else if (busyQ) begin
          rdMux = epc_pkg::BUSY_READ_VAL;
        end else begin
          rdMux = cellRd;
        end
      end
      epc_pkg::OFS_ISTAT: begin
        rdMux = {{(8 - IW){1'b0}}, statQ};
      end
      epc_pkg::OFS_IMASK: begin
        rdMux = {{(8 - IW){1'b0}}, maskQ};
      end
      default: begin
        rdMux = 8'h00;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdataQ <= 32'h0000_0000;
    end else if (rdPendQ) begin
      if (addrQ == epc_pkg::OFS_DATA_POINTER) begin
        hrdataQ <= {21'h000000, dptrQ};
      end else begin
        hrdataQ <= {24'h000000, rdMux};
      end
    end
  end

  assign hrdata = hrdataQ;
  assign hreadyout = hreadyoutQ;
  assign hresp = hrespQ;
  assign irq = irqQ;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_launch;
    launch;
  endsequence

  sequence s_copy_start;
    busyQ && (stateQ == epc_pkg::ST_COPY) && (idxQ == '0);
  endsequence

  property p_launch_busy;
    s_launch |=> s_copy_start ##1 busyQ[*8];
  endproperty
  a_launch_busy: assert property (p_launch_busy)
    else $error("busy not raised and held after launch");

  property p_busy_fall;
    $fell(busyQ) |-> $past(doneEv) && (stateQ == epc_pkg::ST_IDLE);
  endproperty
  a_busy_fall: assert property (p_busy_fall)
    else $error("busy cleared without end of programming");

  property p_mark_clear;
    doneEv |=> (markQ == '0) && !busyQ && statQ[epc_pkg::IRQ_DONE_BIT];
  endproperty
  a_mark_clear: assert property (p_mark_clear)
    else $error("markers or busy not cleared after row write");

  property p_launch_needs_first;
    s_launch |-> pendQ && $past(pendQ) && !$past(wrPendQ || rdPendQ);
  endproperty
  a_launch_needs_first: assert property (p_launch_needs_first)
    else $error("launch without pending first code");

  property p_gap_aborts;
    pendQ && (rdPendQ || (wrPendQ && !ctrlWr))
      |=> !pendQ && statQ[epc_pkg::IRQ_ABORT_BIT]
                         && (stateQ != epc_pkg::ST_COPY);
  endproperty
  a_gap_aborts: assert property (p_gap_aborts)
    else $error("transfer between launch codes did not abort");

  property p_other_write_discards;
    pendQ && ctrlWr && (launchNib != epc_pkg::LAUNCH_SECOND)
      |=> !busyQ || $past(busyQ);
  endproperty
  a_other_write_discards: assert property (p_other_write_discards)
    else $error("wrong second code started programming");

  property p_page_select;
    eeLoad |=> (pageQ == $past(dptrQ[AW-1:BW])) &&
               markQ[$past(dptrQ[BW-1:0])];
  endproperty
  a_page_select: assert property (p_page_select)
    else $error("latch load did not record page and marker");

  property p_page_drop;
    eeLoad && newPage |=> $onehot(markQ);
  endproperty
  a_page_drop: assert property (p_page_drop)
    else $error("bytes of an older page were kept");

  property p_map_follows;
    ctrlWr |=> mapQ == $past(hwdata[epc_pkg::CTRL_MAP_BIT]);
  endproperty
  a_map_follows: assert property (p_map_follows)
    else $error("map enable does not follow control write");

  property p_busy_sw;
    ctrlWr && !launch && !busyQ |=> !busyQ;
  endproperty
  a_busy_sw: assert property (p_busy_sw)
    else $error("software changed the busy flag");

  property p_busy_read;
    rdPendQ && (addrQ == epc_pkg::OFS_DATA) && mapQ && busyQ
      |=> (hrdataQ[7:0] == epc_pkg::BUSY_READ_VAL) && hreadyoutQ;
  endproperty
  a_busy_read: assert property (p_busy_read)
    else $error("eeprom readable while busy");

  property p_read_wait;
    addrTake && !hwrite |=> !hreadyoutQ ##1 hreadyoutQ;
  endproperty
  a_read_wait: assert property (p_read_wait)
    else $error("read wait state not exactly one cycle");
endmodule
`default_nettype wire

// File: shared/epc_pkg.sv
// Behaviour
// - The row that is programmed is the page part of the address used by the most recent latch load.
// - If the latch loads span several pages, only the last page is kept and the bytes loaded under other pages are dropped.
// - Programming starts only after the control register receives 50h and then A0h, in that order; the code compares only bits 7-4, so any 5xh then Axh starts it.
// - A launch sets the busy flag, and the EEPROM cannot be read while the flag is set.
// - The busy flag is cleared by hardware when the page is written, and the done bit of the interrupt status is set on the same edge.
// - The two launch writes (upper nibble 5, then upper nibble A) must follow back to back, or the launch is aborted.
// - A read with the EEPROM mapped returns the stored byte at the data pointer address.
// - Writing 02h to the control register maps the EEPROM into the external-data space.
// - Writing 00h to the control register unmaps the EEPROM and returns data moves to the XRAM.
// - Of the 11 data pointer bits, the upper 4 select the page and the lower 7 select the byte.
// - Each latch byte has a marker set on write; only marked bytes are programmed and all markers clear after the row write.
// - The control register holds the launch command in bits 7-4, map enable in bit 1 and a read-only busy flag in bit 0.
// - Reset clears the map enable bit and the busy flag.
package epc_pkg;
  // ----------------------------------------------------------------
  // register map (byte offsets inside the slave window)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DATA_POINTER = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_ISTAT = 8'h0c;
  localparam logic [7:0] OFS_IMASK = 8'h10;
  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_BUSY_BIT = 0;
  localparam int CTRL_MAP_BIT = 1;
  localparam int CTRL_LAUNCH_LSB = 4;
  localparam int CTRL_LAUNCH_MSB = 7;
  localparam logic [3:0] LAUNCH_FIRST = 4'h5;
  localparam logic [3:0] LAUNCH_SECOND = 4'ha;
  localparam logic RST_MAP = 1'b0;
  localparam logic RST_BUSY = 1'b0;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int EE_ADDR_W = 11;
  localparam int BYTE_SEL_W = 7;
  localparam int PAGE_SEL_W = 4;
  localparam int PAGE_BYTES = 128;
  localparam int EE_BYTES = 2048;
  localparam int XRAM_ADDR_W = 10;
  localparam int XRAM_BYTES = 1024;
  localparam logic [7:0] BUSY_READ_VAL = 8'hff;
  // ----------------------------------------------------------------
  // interrupt status / mask layout
  // ----------------------------------------------------------------
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ABORT_BIT = 1;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int PROG_TIME_NS = 10000;
  localparam int PROG_CYCLES =
    (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // ----------------------------------------------------------------
  // programming sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_COPY = 3'b010,
    ST_WAIT = 3'b100
  } epc_state_t;
endpackage

// File: verif/eeprom_page_program_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module eeprom_page_program_ctrl_bench;
  // short program time keeps the run small
  localparam int PROG = 4;
  localparam int SPAN = 128 + PROG;
  logic sysClk, rst, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int failCount;
  int checks;
  int cyc;

  epc_top #(.PROG_CYCLES(PROG)) i_epc_top (
    .sys_clk(sysClk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq));
  epc_host_model i_epc_host_model (
    .clk(sysClk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));

  initial begin
    sysClk = 1'b0;
    forever #2.5 sysClk = ~sysClk;
  end
  initial cyc = 0;
  always @(posedge sysClk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic endOfTest;
    if (failCount == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    i_epc_host_model.xfer(1'b1, a, d, r);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    i_epc_host_model.xfer(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic ld(input logic [10:0] p, input logic [7:0] d);
    wr(epc_pkg::OFS_DATA_POINTER, {21'h0, p});
    wr(epc_pkg::OFS_DATA, {24'h0, d});
  endtask
  task automatic rdByte(input logic [10:0] p, input logic [7:0] e);
    wr(epc_pkg::OFS_DATA_POINTER, {21'h0, p});
    rdChk(epc_pkg::OFS_DATA, {24'h0, e});
  endtask
  task automatic launchWait;
    logic [31:0] r;
    int t0;
    wr(epc_pkg::OFS_CTRL, 32'h50);
    wr(epc_pkg::OFS_CTRL, 32'ha0);
    t0 = cyc;
    rdChk(epc_pkg::OFS_CTRL, 32'h1);
    wr(epc_pkg::OFS_CTRL, 32'h2);
    rdChk(epc_pkg::OFS_CTRL, 32'h3);
    rdChk(epc_pkg::OFS_DATA, {24'h0, epc_pkg::BUSY_READ_VAL});
    do i_epc_host_model.xfer(1'b0, epc_pkg::OFS_CTRL, 32'h0, r);
    while (r[0] === 1'b1);
    chk({31'h0, (cyc - t0 >= SPAN) && (cyc - t0 <= SPAN + 6)}, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic resetScen;
    rdChk(epc_pkg::OFS_CTRL, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    rdChk(epc_pkg::OFS_ISTAT, 32'h0);
    rdChk(epc_pkg::OFS_IMASK, 32'h0);
    wr(8'h20, 32'hffffffff);
    rdChk(8'h20, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic mapScen;
    wr(epc_pkg::OFS_CTRL, 32'h2);
    rdChk(epc_pkg::OFS_CTRL, 32'h2);
    wr(epc_pkg::OFS_CTRL, 32'h0);
    rdChk(epc_pkg::OFS_CTRL, 32'h0);
    ld(11'h180, 8'h3c);
    rdByte(11'h180, 8'h3c);
  endtask
  task automatic progScen;
    wr(epc_pkg::OFS_IMASK, 32'h1);
    wr(epc_pkg::OFS_CTRL, 32'h2);
    ld(11'h0c0, 8'h5a);
    ld(11'h180, 8'h11);
    ld(11'h1ff, 8'h22);
    launchWait;
    @(posedge sysClk);
    chk({31'h0, irq}, 32'h1);
    rdChk(epc_pkg::OFS_ISTAT, 32'h1);
    @(posedge sysClk);
    chk({31'h0, irq}, 32'h0);
    wr(epc_pkg::OFS_CTRL, 32'h2);
    rdByte(11'h180, 8'h11);
    rdByte(11'h1ff, 8'h22);
    // the second session wanders from row 3 to row 5 before launching
    ld(11'h1ff, 8'h77);
    ld(11'h280, 8'h66);
    launchWait;
    wr(epc_pkg::OFS_CTRL, 32'h2);
    rdByte(11'h280, 8'h66);
    rdByte(11'h1ff, 8'h22);
    rdByte(11'h180, 8'h11);
    wr(epc_pkg::OFS_CTRL, 32'h0);
    rdByte(11'h180, 8'h3c);
    rdChk(epc_pkg::OFS_ISTAT, 32'h1);
  endtask
  task automatic abortScen;
    wr(epc_pkg::OFS_IMASK, 32'h0);
    wr(epc_pkg::OFS_CTRL, 32'h50);
    wr(epc_pkg::OFS_DATA_POINTER, 32'h0);
    wr(epc_pkg::OFS_CTRL, 32'ha0);
    rdChk(epc_pkg::OFS_CTRL, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(epc_pkg::OFS_IMASK, 32'h2);
    repeat (2) @(posedge sysClk);
    chk({31'h0, irq}, 32'h1);
    rdChk(epc_pkg::OFS_ISTAT, 32'h2);
    wr(epc_pkg::OFS_CTRL, 32'h50);
    wr(epc_pkg::OFS_CTRL, 32'h2);
    wr(epc_pkg::OFS_CTRL, 32'ha0);
    rdChk(epc_pkg::OFS_CTRL, 32'h0);
    rdChk(epc_pkg::OFS_ISTAT, 32'h2);
    @(posedge sysClk);
    chk({31'h0, irq}, 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge sysClk);
    failCount++;
    endOfTest;
  end
  initial begin
    failCount = 0;
    checks = 0;
    rst = 1'b1;
    repeat (12) @(posedge sysClk);
    rst <= 1'b0;
    resetScen;
    mapScen;
    progScen;
    abortScen;
    endOfTest;
  end
endmodule
`default_nettype wire

// File: verif/epc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// bus master standing in for the processor core
// ----------------------------------------------------------------
module epc_host_model (
  input wire logic clk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // caller sits just after a rising edge; no cycle count is assumed,
  // only the bench watchdog ends a stuck wait
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    // a read leaves junk on the data lines so a stale value never helps
    hwdata <= wr ? wd : ~hwdata;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
endmodule
`default_nettype wire
